// ---- hw/irsc_codec.sv ----
// ----------------------------------------------------------------
// receive pulse queue
// ----------------------------------------------------------------
module irsc_fifo
    import irsc_pkg::*;
#(
    parameter int unsigned WIDTH = 1,                   // token width
    parameter int unsigned DEPTH = 16                   // entries
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         flush,
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire logic [WIDTH-1:0]             in_data,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [WIDTH-1:0]                  out_data,
    output logic [$clog2(DEPTH+1)-1:0]        level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);

    // refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("irsc_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;                // storage
        logic [AW-1:0]               wptr;               // write pointer
        logic [AW-1:0]               rptr;               // read pointer
        logic [CW-1:0]               count;              // entries held
    } irsc_fifo_s;

    irsc_fifo_s q;                                       // registered state
    irsc_fifo_s d;                                       // next state
    logic       do_push;                                 // accepted write
    logic       do_pop;                                  // accepted read

    // honest flags from the count
    assign in_ready  = (q.count != CW'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data  = q.mem[q.rptr];
    assign level     = q.count;

    // next-state logic
    always_comb begin
        d       = q;
        do_push = in_valid && in_ready;
        do_pop  = out_valid && out_ready;
        if (flush) begin                                 // drop everything held
            d.wptr  = '0;
            d.rptr  = '0;
            d.count = '0;
        end else begin
            if (do_push) begin                           // store and advance
                d.mem[q.wptr] = in_data;
                d.wptr        = q.wptr + AW'(1);
            end
            if (do_pop) begin                            // release head
                d.rptr = q.rptr + AW'(1);
            end
            if (do_push && !do_pop) begin
                d.count = q.count + CW'(1);
            end else if (do_pop && !do_push) begin
                d.count = q.count - CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // irsc_fifo

// ----------------------------------------------------------------
// infrared pulse codec with apb control
// ----------------------------------------------------------------
module irsc_codec
    import irsc_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 16              // receive pulse queue depth
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [IRSC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    oversample_clock_in,
    input  wire logic                    uart_serial_out,
    output logic                         uart_rx_out,
    input  wire logic                    optical_rx_in,
    output logic                         optical_tx_out,
    output logic                         osc_power_down
);
    localparam int unsigned LW = $clog2(FIFO_DEPTH+1);

    // level field must fit the status word
    if (FIFO_DEPTH < 2 || LW > 24) begin : g_bad
        $error("irsc_codec: FIFO_DEPTH out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  tx_sync;                            // transmit input synchroniser
        logic        tx_prev;                            // last synced transmit level
        logic [1:0]  rx_sync;                            // optical input synchroniser
        logic        rx_prev;                            // last synced optical level
        logic [1:0]  ck_sync;                            // 16x clock synchroniser
        logic        ck_prev;                            // last synced 16x level
        logic [6:0]  div_cnt;                            // crystal divider
        irsc_enc_e   enc_state;                          // encoder state
        logic [3:0]  enc_cnt;                            // tick within bit
        logic        mod_prev;                           // last modulation level
        logic [2:0]  mono_cnt;                           // fixed pulse remaining
        irsc_dec_e   dec_state;                          // decoder state
        logic [3:0]  dec_cnt;                            // tick within stretch
        logic        tx_out;                             // optical output flop
        logic        rx_out;                             // uart receive flop
        logic [2:0]  rate_sel;                           // divisor code
        logic        ext_clk_sel;                        // clock source select
        logic        fixed_pulse_select;                 // transmit mode
        logic        decoder_reset_n;                    // decoder hold, active low
        logic        pwr_down;                           // oscillator off request
        logic        overflow;                           // pulse lost, sticky
        logic [31:0] rdata;                              // read data flop
        logic        err;                                // error response flop
    } irsc_core_s;

    irsc_core_s q;                                       // registered state
    irsc_core_s d;                                       // next state

    logic          tick;                                 // one 16x period enable
    logic          tx_fall;                              // transmit falling edge
    logic          rx_fall;                              // optical falling edge
    logic          mod_now;                              // internal modulation
    logic          mod_rise;                             // modulation rising edge
    logic          wr_acc;                               // write access phase
    logic          rd_setup;                             // setup phase of any access
    logic          hit_ctrl;                             // control decoded
    logic          hit_stat;                             // status decoded
    logic          q_push;                               // pulse offered to queue
    logic          q_ready;                              // queue can take a pulse
    logic          q_valid;                              // pulse waiting
    logic          q_pop;                                // stretcher takes pulse
    logic          q_flush;                              // decoder held in reset
    logic [LW-1:0] q_level;                              // queue fill level

    // ------------------------------------------------------------
    // pulse queue between edge detector and stretcher
    // ------------------------------------------------------------
    irsc_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .flush     (q_flush),
        .in_valid  (q_push),
        .in_ready  (q_ready),
        .in_data   (1'b0),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (),
        .level     (q_level)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready         = 1'b1;                        // zero-wait slave
    assign prdata         = q.rdata;
    assign pslverr        = q.err;
    assign optical_tx_out = q.tx_out;
    assign uart_rx_out    = q.rx_out;
    assign osc_power_down = q.ext_clk_sel || q.pwr_down;

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    always_comb begin
        // 16x tick from external clock edge or divided crystal
        if (q.ext_clk_sel) begin
            tick = q.ck_sync[1] && !q.ck_prev;
        end else begin
            tick = !q.pwr_down && (q.div_cnt >= irsc_rate_div(q.rate_sel) - 7'h01);
        end
        tx_fall  = !q.tx_sync[1] && q.tx_prev;
        rx_fall  = !q.rx_sync[1] && q.rx_prev;
        mod_now  = (q.enc_state == IRSC_ENC_BIT) && (q.enc_cnt >= IRSC_ENC_DELAY)
                   && (q.enc_cnt < IRSC_ENC_DELAY + IRSC_ENC_HIGH);
        mod_rise = mod_now && !q.mod_prev;
        wr_acc   = psel && penable && pwrite;
        rd_setup = psel && !penable;
        hit_ctrl = (paddr == IRSC_CTRL_OFF);
        hit_stat = (paddr == IRSC_STATUS_OFF);
        q_flush  = !q.decoder_reset_n;
        q_push   = rx_fall && q.decoder_reset_n;
        q_pop    = (q.dec_state == IRSC_DEC_IDLE && q.decoder_reset_n)
                   || (q.dec_state == IRSC_DEC_STRETCH && tick && q.dec_cnt == IRSC_BIT_LAST);
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // synchronisers, first stage read only by the second
        d.tx_sync = {q.tx_sync[0], uart_serial_out};
        d.rx_sync = {q.rx_sync[0], optical_rx_in};
        d.ck_sync = {q.ck_sync[0], oversample_clock_in};
        d.tx_prev = q.tx_sync[1];
        d.rx_prev = q.rx_sync[1];
        d.ck_prev = q.ck_sync[1];

        // crystal divider, restarts on each tick
        if (q.ext_clk_sel || q.pwr_down || tick) begin
            d.div_cnt = '0;
        end else begin
            d.div_cnt = q.div_cnt + 7'h01;
        end

        // encoder: one bit frame per bit time while the space lasts
        unique case (q.enc_state)
            IRSC_ENC_IDLE: begin
                if (tx_fall) begin
                    d.enc_state = IRSC_ENC_BIT;
                    d.enc_cnt   = '0;
                end
            end
            IRSC_ENC_BIT: begin
                if (tick) begin
                    d.enc_cnt = q.enc_cnt + 4'h1;        // wraps after last tick
                    if (q.tx_sync[1] && (q.enc_cnt == IRSC_BIT_LAST
                            || q.enc_cnt == IRSC_ENC_DELAY - 4'h1)) begin
                        d.enc_state = IRSC_ENC_IDLE;     // mark at end or mid-bit
                    end
                end
            end
        endcase

        // fixed pulse monoshot on crystal cycles
        d.mod_prev = mod_now;
        if (mod_rise) begin
            d.mono_cnt = IRSC_MONO_CYCLES;
        end else if (q.mono_cnt != '0) begin
            d.mono_cnt = q.mono_cnt - 3'h1;
        end

        // transmit mode select
        if (q.fixed_pulse_select) begin
            d.tx_out = mod_rise || (q.mono_cnt > 3'h1);
        end else begin
            d.tx_out = mod_now;
        end

        // decoder: stretch each queued pulse to a bit time
        if (!q.decoder_reset_n) begin
            d.dec_state = IRSC_DEC_IDLE;
            d.dec_cnt   = '0;
            d.rx_out    = 1'b1;
        end else begin
            unique case (q.dec_state)
                IRSC_DEC_IDLE: begin
                    d.rx_out = 1'b1;
                    if (q_valid) begin
                        d.dec_state = IRSC_DEC_STRETCH;
                        d.dec_cnt   = '0;
                        d.rx_out    = 1'b0;
                    end
                end
                IRSC_DEC_STRETCH: begin
                    if (tick) begin
                        d.dec_cnt = q.dec_cnt + 4'h1;
                        if (q.dec_cnt == IRSC_BIT_LAST) begin
                            if (q_valid) begin
                                d.rx_out = 1'b0;         // back-to-back space
                            end else begin
                                d.dec_state = IRSC_DEC_IDLE;
                                d.rx_out    = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end

        // control register write
        if (wr_acc && hit_ctrl) begin
            d.rate_sel           = pwdata[IRSC_CTRL_RATE_LSB +: 3];
            d.ext_clk_sel        = pwdata[IRSC_CTRL_EXTCLK];
            d.fixed_pulse_select = pwdata[IRSC_CTRL_FIXED];
            d.decoder_reset_n    = pwdata[IRSC_CTRL_DECRST_N];
            d.pwr_down           = pwdata[IRSC_CTRL_PWRDN];
        end

        // overflow: a lost pulse sets, write one clears, set wins
        if (q_push && !q_ready) begin
            d.overflow = 1'b1;
        end else if (wr_acc && hit_stat && pwdata[IRSC_STAT_OVERFLOW]) begin
            d.overflow = 1'b0;
        end

        // read data and error captured in the setup phase
        if (rd_setup) begin
            d.rdata = '0;
            d.err   = !(hit_ctrl || hit_stat);
            if (!pwrite && hit_ctrl) begin
                d.rdata[IRSC_CTRL_RATE_LSB +: 3] = q.rate_sel;
                d.rdata[IRSC_CTRL_EXTCLK]        = q.ext_clk_sel;
                d.rdata[IRSC_CTRL_FIXED]         = q.fixed_pulse_select;
                d.rdata[IRSC_CTRL_DECRST_N]      = q.decoder_reset_n;
                d.rdata[IRSC_CTRL_PWRDN]         = q.pwr_down;
            end else if (!pwrite && hit_stat) begin
                d.rdata[IRSC_STAT_ENC_BUSY]           = (q.enc_state == IRSC_ENC_BIT);
                d.rdata[IRSC_STAT_DEC_BUSY]           = (q.dec_state == IRSC_DEC_STRETCH);
                d.rdata[IRSC_STAT_OVERFLOW]           = q.overflow;
                d.rdata[IRSC_STAT_LEVEL_LSB +: LW]    = q_level;
            end
        end else if (!psel) begin
            d.err = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q                    <= '0;
            q.tx_sync            <= 2'h3;                // idle mark
            q.tx_prev            <= 1'b1;
            q.rx_sync            <= 2'h3;
            q.rx_prev            <= 1'b1;
            q.rx_out             <= 1'b1;
            q.decoder_reset_n    <= IRSC_CTRL_RESET[IRSC_CTRL_DECRST_N];
        end else begin
            q <= d;
        end
    end
endmodule // irsc_codec

// ---- hw/irsc_pkg.sv ----
// Functional notes
// - external 16x clock sampled on rising edges
// - transmit falling edge starts a modulated pulse
// - receive output is demodulated optical input
// - external clock selected powers oscillator down
// - decoder reset low resets receive decoder
// - decoder reset low suppresses all reception
// - decoder accepts short or 3/16 pulses
// - standard 3/16 mode and fixed pulse mode
// - wait 7 ticks, high 3, marks silent
// - each queued optical pulse gives 16-tick low
// - rate code selects crystal divisor
// - fixed mode pulse is 6 crystal cycles
package irsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned   IRSC_ADDR_W     = 12;          // apb address width
    localparam logic [11:0]   IRSC_CTRL_OFF   = 12'h000;     // control register
    localparam logic [11:0]   IRSC_STATUS_OFF = 12'h004;     // status register

    // control fields
    localparam int unsigned   IRSC_CTRL_RATE_LSB  = 0;       // rate code, 3 bits
    localparam int unsigned   IRSC_CTRL_EXTCLK    = 3;       // external clock select
    localparam int unsigned   IRSC_CTRL_FIXED     = 4;       // fixed pulse select
    localparam int unsigned   IRSC_CTRL_DECRST_N  = 5;       // decoder reset, active low
    localparam int unsigned   IRSC_CTRL_PWRDN     = 6;       // oscillator power-down
    localparam logic [31:0]   IRSC_CTRL_RESET     = 32'h0000_0020;

    // status fields
    localparam int unsigned   IRSC_STAT_ENC_BUSY  = 0;       // encoder in a bit
    localparam int unsigned   IRSC_STAT_DEC_BUSY  = 1;       // decoder stretching
    localparam int unsigned   IRSC_STAT_OVERFLOW  = 2;       // sticky, write one clears
    localparam int unsigned   IRSC_STAT_LEVEL_LSB = 8;       // fifo fill level

    // ------------------------------------------------------------
    // timing counts in 16x ticks and crystal cycles
    // ------------------------------------------------------------
    localparam logic [3:0]    IRSC_ENC_DELAY   = 4'h7;       // ticks before pulse
    localparam logic [3:0]    IRSC_ENC_HIGH    = 4'h3;       // pulse width in ticks
    localparam logic [3:0]    IRSC_BIT_LAST    = 4'hF;       // last tick of a bit
    localparam logic [2:0]    IRSC_MONO_CYCLES = 3'h6;       // fixed pulse width

    // crystal divisors per rate code
    localparam logic [6:0]    IRSC_DIV_0 = 7'h02;
    localparam logic [6:0]    IRSC_DIV_1 = 7'h04;
    localparam logic [6:0]    IRSC_DIV_2 = 7'h0C;
    localparam logic [6:0]    IRSC_DIV_3 = 7'h18;
    localparam logic [6:0]    IRSC_DIV_4 = 7'h06;
    localparam logic [6:0]    IRSC_DIV_5 = 7'h30;
    localparam logic [6:0]    IRSC_DIV_6 = 7'h60;
    localparam logic [6:0]    IRSC_DIV_7 = 7'h01;            // test, no division

    // ------------------------------------------------------------
    // state enumerations
    // ------------------------------------------------------------
    typedef enum logic {IRSC_ENC_IDLE, IRSC_ENC_BIT} irsc_enc_e;
    typedef enum logic {IRSC_DEC_IDLE, IRSC_DEC_STRETCH} irsc_dec_e;

    // rate code to crystal divisor
    function automatic logic [6:0] irsc_rate_div(input logic [2:0] code);
        logic [6:0] d;
        d = IRSC_DIV_7;
        unique case (code)
            3'h0: d = IRSC_DIV_0;
            3'h1: d = IRSC_DIV_1;
            3'h2: d = IRSC_DIV_2;
            3'h3: d = IRSC_DIV_3;
            3'h4: d = IRSC_DIV_4;
            3'h5: d = IRSC_DIV_5;
            3'h6: d = IRSC_DIV_6;
            3'h7: d = IRSC_DIV_7;
        endcase
        return d;
    endfunction

endpackage

// ---- tb/irsc_codec_sva.sv ----
// port level checks of the codec
module irsc_codec_chk
    import irsc_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [IRSC_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   oversample_clock_in,
    input wire logic                   uart_serial_out,
    input wire logic                   uart_rx_out,
    input wire logic                   optical_rx_in,
    input wire logic                   optical_tx_out,
    input wire logic                   osc_power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] ctl;                   // shadow of control bits
    logic [5:0] hi;                    // cycles transmit input stayed high
    logic       fast;                  // crystal, no division, standard mode
    assign fast = ctl[2:0] == 3'h7 && ctl[4:3] == 2'h0;
    // shadow follows apb writes at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 7'h20;
            hi <= 6'h00;
        end else begin
            if (psel && penable && pwrite && paddr == IRSC_CTRL_OFF) ctl <= pwdata[6:0];
            hi <= !uart_serial_out ? 6'h00 : (hi == 6'h3F ? hi : hi + 6'h01);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_tx3;
        optical_tx_out [*3] ##1 !optical_tx_out;
    endsequence
    osc_pd_a: assert property (osc_power_down == (ctl[3] | ctl[6]))
        else $error("oscillator power-down wrong");
    tx_std_a: assert property ($rose(optical_tx_out) && fast |-> s_tx3)
        else $error("standard pulse not three ticks");
    tx_fix_a: assert property ($rose(optical_tx_out) && ctl[4] |-> optical_tx_out [*6] ##1 !optical_tx_out)
        else $error("fixed pulse not six cycles");
    tx_start_a: assert property ($fell(uart_serial_out) && fast && hi > 6'h1E |-> ##[7:14] $rose(optical_tx_out) ##0 s_tx3)
        else $error("space gave no pulse");
    rx_str_a: assert property ($fell(uart_rx_out) && fast |=> !uart_rx_out [*8] ##1 !uart_rx_out [*6])
        else $error("stretch too short");
    rx_start_a: assert property ($fell(optical_rx_in) && ctl[5] && uart_rx_out |-> ##[2:8] !uart_rx_out)
        else $error("pulse not demodulated");
    rx_mute_a: assert property (!ctl[5] && !$past(ctl[5]) |-> uart_rx_out)
        else $error("reception while decoder held");
    idle_rst_a: assert property ($rose(presetn) |-> uart_rx_out && !optical_tx_out)
        else $error("outputs not idle after reset");
    apb_err_a: assert property (psel && penable && paddr > IRSC_STATUS_OFF |-> pslverr)
        else $error("unmapped access accepted");
endmodule // irsc_codec_chk

// ---- tb/irsc_far_end.sv ----
// host uart and optical transceiver on the far side of the codec
module irsc_far_end (
    input  wire logic pclk,
    output logic      uart_serial_out,
    output logic      optical_rx_in,
    output logic      oversample_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;             // divider phase for the 16x clock
    initial begin
        uart_serial_out = 1'b1;        // idle mark
        optical_rx_in = 1'b1;          // receiver idles high, pulled up
        oversample_clock_in = 1'b0;
    end
    // free running 16x clock, period 8 pclk, as a uart baud output
    always @(posedge pclk) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) oversample_clock_in <= !oversample_clock_in;
    end
    // one space held low for n cycles, then back to mark
    task automatic space(input int n);
        @(posedge pclk);
        uart_serial_out <= 1'b0;
        repeat (n) @(posedge pclk);
        uart_serial_out <= 1'b1;
    endtask
    // short optical pulse, three cycles low
    task automatic flash();
        @(posedge pclk);
        optical_rx_in <= 1'b0;
        repeat (3) @(posedge pclk);
        optical_rx_in <= 1'b1;
    endtask
endmodule // irsc_far_end

// ---- tb/tb.sv ----
module tb import irsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, er, uart_rx_out, optical_tx_out, osc_power_down;
    logic        oversample_clock_in, uart_serial_out, optical_rx_in;
    int          fails = 0, cmp_count = 0, seed = 32'h99FF16CF, w, d, nb, i;
    initial forever #10 pclk = !pclk;
    irsc_codec #(.FIFO_DEPTH(16)) irsc_codec_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .oversample_clock_in, .uart_serial_out,
        .uart_rx_out, .optical_rx_in, .optical_tx_out, .osc_power_down);
    irsc_far_end irsc_far_end_i (.pclk, .uart_serial_out, .optical_rx_in, .oversample_clock_in);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tmo();
        fails++;
        tally_and_finish();
    endtask
    // one apb transfer, read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, dt};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        if (pready !== 1'b1) tmo();
    endtask
    function automatic logic act(input logic rx);
        return rx ? uart_rx_out === 1'b0 : optical_tx_out === 1'b1;
    endfunction
    // wait for a pulse, then count its cycles
    task automatic width(input logic rx);
        int n;
        w = 0;
        for (n = 0; n < 5000 && !act(rx); n++) @(posedge pclk);
        if (n == 5000) tmo();
        for (w = 0; w < 5000 && act(rx); w++) @(posedge pclk);
    endtask
    function automatic int dv(input int c);
        int t[8] = '{2, 4, 12, 24, 6, 48, 96, 1};
        return t[c];
    endfunction
    initial begin
        repeat (100000) @(posedge pclk);
        tmo();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("rx idle", uart_rx_out, 1);
        chk("tx idle", optical_tx_out, 0);
        apb(0, IRSC_CTRL_OFF, 0);
        chk("ctrl reset", rd, 32'h20);
        apb(0, 12'h010, 0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            d = dv(i);
            nb = 1 + {$random(seed)} % 3;
            apb(1, IRSC_CTRL_OFF, 32'h20 | i);
            chk("osc on", osc_power_down, 0);
            fork
                irsc_far_end_i.space(nb * 16 * d);
                repeat (nb) begin
                    width(0);
                    chk("std width", w, 3 * d);
                end
            join
            repeat (32 * d) @(posedge pclk);
        end
        apb(1, IRSC_CTRL_OFF, 32'h30);
        fork irsc_far_end_i.space(32); width(0); join
        chk("fixed width", w, 6);
        repeat (64) @(posedge pclk);
        apb(1, IRSC_CTRL_OFF, 32'h28);
        @(posedge pclk);
        chk("osc off", osc_power_down, 1);
        fork irsc_far_end_i.space(128); width(0); join
        chk("ext width", w, 24);
        $display("test encoder done");
        for (i = 0; i < 2; i++) begin
            d = i ? 4 : 1;
            apb(1, IRSC_CTRL_OFF, i ? 32'h21 : 32'h27);
            fork irsc_far_end_i.flash(); width(1); join
            chk("stretch", w >= 15 * d && w <= 16 * d + 1, 1);
            repeat (40) @(posedge pclk);
        end
        apb(1, IRSC_CTRL_OFF, 32'h25);
        repeat (20) begin
            irsc_far_end_i.flash();
            repeat (4 + {$random(seed)} % 4) @(posedge pclk);
        end
        apb(0, IRSC_STATUS_OFF, 0);
        chk("level", rd[12:8], 16);
        chk("overflow", rd[2], 1);
        apb(1, IRSC_STATUS_OFF, 32'h4);
        apb(0, IRSC_STATUS_OFF, 0);
        chk("overflow clear", rd[2], 0);
        apb(1, IRSC_CTRL_OFF, 32'h45);
        fork irsc_far_end_i.flash(); repeat (10) @(posedge pclk); join
        chk("muted", uart_rx_out, 1);
        chk("pwrdn", osc_power_down, 1);
        apb(0, IRSC_STATUS_OFF, 0);
        chk("flushed", rd[12:8], 0);
        $display("test decoder done");
        tally_and_finish();
    end
endmodule // tb
bind irsc_codec irsc_codec_chk irsc_codec_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .oversample_clock_in, .uart_serial_out,
    .uart_rx_out, .optical_rx_in, .optical_tx_out, .osc_power_down);
